// [hdl/spvp_port.sv]
// serial program/verify port: mode entry, 20-bit serial shifter on sclk, table pointer and table access
// assumes mclk system logic for core, pointer registers and memory; sclk comes from the external programmer
`timescale 1ns/100ps
`include "spvp_consts.svh"
module spvp_port (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic prog_serial_io_i,
   output logic prog_serial_io_o,
   output logic prog_serial_io_oe_n,
   input wire logic master_clear_vpp_pin,
   input wire logic high_programming_voltage,
   input wire logic low_volt_entry_pin,
   input wire logic low_volt_enable_bit,
   input wire logic [8:0] code_protect,
   output logic prog_active,
   output logic hv_mode,
   output logic gpio_hiz,
   output logic low_volt_pin_dedicated,
   output logic core_instr_valid,
   output logic [15:0] core_instr,
   input wire logic sfr_we,
   input wire logic [11:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic mem_rd,
   output logic mem_wr,
   output logic [21:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic [3:0] mem_panel,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_busy,
   output logic prog_start,
   output logic prog_hold
);

   // read commands drive the upper operand byte back out
   function automatic logic cmd_is_read(input logic [3:0] cmd);
      cmd_is_read = (cmd == `SPVP_CMD_SHIFT_LATCH) || (cmd == `SPVP_CMD_RD) || (cmd == `SPVP_CMD_RD_POSTINC) ||
                    (cmd == `SPVP_CMD_RD_POSTDEC) || (cmd == `SPVP_CMD_RD_PREINC);
   endfunction : cmd_is_read

   // region of a table address
   function automatic spvp_pkg::spvp_region_type region_of(input logic [21:0] a);
      if (a <= `SPVP_CODE_LAST) region_of = spvp_pkg::SPVP_RG_CODE;
      else if (a >= `SPVP_ID_FIRST && a <= `SPVP_ID_LAST) region_of = spvp_pkg::SPVP_RG_ID;
      else if (a >= `SPVP_CFG_FIRST && a <= `SPVP_CFG_LAST) region_of = spvp_pkg::SPVP_RG_CFG;
      else if (a >= `SPVP_DEVID_FIRST) region_of = spvp_pkg::SPVP_RG_DEVID;
      else region_of = spvp_pkg::SPVP_RG_NONE;
   endfunction : region_of

   // protection applies to code only; boot region has its own bit
   function automatic logic is_protected(input logic [21:0] a, input logic [8:0] prot);
      if (region_of(a) != spvp_pkg::SPVP_RG_CODE) is_protected = 1'b0;
      else if (a <= `SPVP_BOOT_LAST) is_protected = prot[`SPVP_PROT_BOOT];
      else is_protected = prot[a[`SPVP_BLOCK_MSB:`SPVP_BLOCK_LSB]];
   endfunction : is_protected

   // mclk side declarations
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   logic [4:0] pin_old_q;
   spvp_pkg::spvp_mode_type mode_q;
   logic [2:0] rd_t_s_q;
   logic [2:0] wr_t_s_q;
   logic [1:0] bit3_s_q;
   logic rd_pend_q;
   logic wr_pend_q;
   spvp_pkg::spvp_exec_type ex_q;
   logic [7:0] ptr_low_q;
   logic [7:0] ptr_high_q;
   logic [7:0] ptr_upper_q;
   logic [21:0] ptr;
   logic [7:0] table_latch_register_q;
   logic rd_ack_t_q;
   logic [3:0] rd_cmd_q;
   logic armed_q;
   logic rd_go;
   logic wr_go;
   // sclk side declarations
   // no reset reaches the link domain, so the flags, counter and output byte start from known levels; sh_q, cmd_q and frame_q do not
   logic act_p_q = 1'b0;
   logic act_n_q = 1'b0;
   logic [4:0] cnt_q = 5'h00;
   logic [14:0] sh_q;
   logic [3:0] cmd_q;
   spvp_pkg::spvp_frame_type frame_q;
   logic rd_t_q = 1'b0;
   logic wr_t_q = 1'b0;
   logic bit3_q = 1'b0;
   logic last_q = 1'b0;
   logic [1:0] ack_s_q = 2'h0;
   logic [7:0] out_q = 8'h00;
   logic drive_q = 1'b0;

   // pin synchronisers: mclr high, vpp, entry pin, sclk level, data level
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
         pin_old_q <= 5'h00;
      end else begin
         pin_s1_q <= {master_clear_vpp_pin, high_programming_voltage, low_volt_entry_pin, sclk, prog_serial_io_i};
         pin_s2_q <= pin_s1_q;
         pin_old_q <= pin_s2_q;
      end
   end

   // mode entry: clock and data must be low when the supply pin rises; exit when it drops
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_q <= spvp_pkg::SPVP_MODE_OFF;
      end else begin
         case (mode_q)
            spvp_pkg::SPVP_MODE_OFF: begin
               if (pin_s2_q[3] && !pin_old_q[3] && pin_s2_q[1:0] == 2'h0) begin
                  mode_q <= spvp_pkg::SPVP_MODE_HV;
               end else if (low_volt_enable_bit && pin_s2_q[2] && pin_s2_q[4] && !pin_old_q[4] &&
                            pin_s2_q[1:0] == 2'h0) begin
                  mode_q <= spvp_pkg::SPVP_MODE_LV;
               end
            end
            spvp_pkg::SPVP_MODE_HV: begin
               if (!pin_s2_q[3]) mode_q <= spvp_pkg::SPVP_MODE_OFF;
            end
            spvp_pkg::SPVP_MODE_LV: begin
               if (!pin_s2_q[4] || !pin_s2_q[2] || !low_volt_enable_bit) mode_q <= spvp_pkg::SPVP_MODE_OFF;
            end
            default: mode_q <= spvp_pkg::SPVP_MODE_OFF;
         endcase
      end
   end

   assign prog_active = (mode_q != spvp_pkg::SPVP_MODE_OFF);
   assign hv_mode = (mode_q == spvp_pkg::SPVP_MODE_HV);
   assign gpio_hiz = prog_active;
   assign low_volt_pin_dedicated = low_volt_enable_bit;

   // link toggles cross in on three flops, the fourth-clock level on two; the third toggle flop is only for edges
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_t_s_q <= 3'h0;
         wr_t_s_q <= 3'h0;
         bit3_s_q <= 2'h0;
      end else begin
         rd_t_s_q <= {rd_t_s_q[1:0], rd_t_q};
         wr_t_s_q <= {wr_t_s_q[1:0], wr_t_q};
         bit3_s_q <= {bit3_s_q[0], bit3_q};
      end
   end

   // requests wait here while a self-timed erase keeps the array busy; a new event beats the clear
   assign rd_go = rd_pend_q && !mem_busy && ex_q == spvp_pkg::SPVP_EX_IDLE;
   assign wr_go = wr_pend_q && !mem_busy && ex_q == spvp_pkg::SPVP_EX_IDLE && !rd_pend_q;
   always_ff @(posedge mclk) begin
      if (sys_rst || !prog_active) begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
      end else begin
         rd_pend_q <= (rd_t_s_q[2] ^ rd_t_s_q[1]) || (rd_pend_q && !rd_go);
         wr_pend_q <= (wr_t_s_q[2] ^ wr_t_s_q[1]) || (wr_pend_q && !wr_go);
      end
   end

   assign ptr = {ptr_upper_q[5:0], ptr_high_q, ptr_low_q};

   // read executor: pre-increment, fetch, latch, post-step, then hand the byte back to the link
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ex_q <= spvp_pkg::SPVP_EX_IDLE;
         rd_cmd_q <= 4'h0;
         table_latch_register_q <= 8'h00;
         rd_ack_t_q <= 1'b0;
      end else begin
         case (ex_q)
            spvp_pkg::SPVP_EX_IDLE: begin
               if (rd_go) begin
                  rd_cmd_q <= cmd_q; // stable since the command end, the toggle guards it
                  ex_q <= (cmd_q == `SPVP_CMD_SHIFT_LATCH) ? spvp_pkg::SPVP_EX_WAIT : spvp_pkg::SPVP_EX_READ;
               end
            end
            spvp_pkg::SPVP_EX_READ: ex_q <= spvp_pkg::SPVP_EX_WAIT;
            spvp_pkg::SPVP_EX_WAIT: begin
               if (rd_cmd_q != `SPVP_CMD_SHIFT_LATCH) begin
                  table_latch_register_q <= is_protected(mem_addr, code_protect) ? 8'h00 : mem_rdata;
               end
               rd_ack_t_q <= ~rd_ack_t_q;
               ex_q <= spvp_pkg::SPVP_EX_IDLE;
            end
            default: ex_q <= spvp_pkg::SPVP_EX_IDLE;
         endcase
      end
   end

   // table pointer: core writes by data-space address, the port itself steps it
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ptr_low_q <= 8'h00;
         ptr_high_q <= 8'h00;
         ptr_upper_q <= 8'h00;
      end else if (rd_go && cmd_q == `SPVP_CMD_RD_PREINC) begin
         {ptr_upper_q[5:0], ptr_high_q, ptr_low_q} <= ptr + `SPVP_RD_STEP;
      end else if (ex_q == spvp_pkg::SPVP_EX_WAIT && rd_cmd_q == `SPVP_CMD_RD_POSTINC) begin
         {ptr_upper_q[5:0], ptr_high_q, ptr_low_q} <= ptr + `SPVP_RD_STEP;
      end else if (ex_q == spvp_pkg::SPVP_EX_WAIT && rd_cmd_q == `SPVP_CMD_RD_POSTDEC) begin
         {ptr_upper_q[5:0], ptr_high_q, ptr_low_q} <= ptr - `SPVP_RD_STEP;
      end else if (wr_go && frame_q.cmd == `SPVP_CMD_WR_POSTINC) begin
         {ptr_upper_q[5:0], ptr_high_q, ptr_low_q} <= ptr + `SPVP_WR_STEP;
      end else if (wr_go && frame_q.cmd == `SPVP_CMD_WR_POSTDEC) begin
         {ptr_upper_q[5:0], ptr_high_q, ptr_low_q} <= ptr - `SPVP_WR_STEP;
      end else if (sfr_we) begin
         // the core loads the pointer between commands; the port's own steps take priority
         case (sfr_addr)
            `SPVP_SFR_PTR_LOW: ptr_low_q <= sfr_wdata;
            `SPVP_SFR_PTR_HIGH: ptr_high_q <= sfr_wdata;
            `SPVP_SFR_PTR_UPPER: ptr_upper_q <= sfr_wdata & `SPVP_UPPER_MASK;
            default: ptr_low_q <= ptr_low_q;
         endcase
      end
   end

   // pointer readback, bits above address 21 read zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sfr_rdata <= 8'h00;
      end else begin
         case (sfr_addr)
            `SPVP_SFR_PTR_LOW: sfr_rdata <= ptr_low_q;
            `SPVP_SFR_PTR_HIGH: sfr_rdata <= ptr_high_q;
            `SPVP_SFR_PTR_UPPER: sfr_rdata <= ptr_upper_q & `SPVP_UPPER_MASK;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // write-side execution: core instruction, table write, start of programming
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         core_instr_valid <= 1'b0;
         core_instr <= 16'h0000;
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         mem_addr <= 22'h000000;
         mem_wdata <= 16'h0000;
         mem_panel <= 4'h0;
         prog_start <= 1'b0;
      end else begin
         core_instr_valid <= wr_go && frame_q.cmd == `SPVP_CMD_CORE;
         mem_wr <= wr_go && frame_q.cmd[3:2] == 2'h3;
         prog_start <= wr_go && frame_q.cmd == `SPVP_CMD_WR_PROG;
         mem_rd <= ex_q == spvp_pkg::SPVP_EX_READ;
         if (wr_go && frame_q.cmd == `SPVP_CMD_CORE) core_instr <= frame_q.operand;
         if (wr_go) mem_wdata <= frame_q.operand;
         if (wr_go || ex_q == spvp_pkg::SPVP_EX_READ) begin
            mem_addr <= ptr;
            mem_panel <= ptr[`SPVP_PANEL_MSB:`SPVP_PANEL_LSB];
         end
      end
   end

   // programming runs while the fourth clock of the next instruction stays high after a start
   always_ff @(posedge mclk) begin
      if (sys_rst || !prog_active) begin
         armed_q <= 1'b0;
      end else if (wr_go && frame_q.cmd == `SPVP_CMD_WR_PROG) begin
         armed_q <= 1'b1;
      end else if (wr_go) begin
         armed_q <= 1'b0; // a follow-up core or write instruction ends the programming window
      end
   end
   assign prog_hold = armed_q && bit3_s_q[1] && pin_s2_q[1];

   // link clock domain: mode flag enters on a rising flop then a falling flop
   always_ff @(posedge sclk) begin
      act_p_q <= prog_active;
   end
   always_ff @(negedge sclk) begin
      act_n_q <= act_p_q;
   end

   // capture on each falling edge, lsb first; a fall seen before the flag settles starts a frame
   always_ff @(negedge sclk) begin
      if (!act_n_q || cnt_q == `SPVP_BIT_LAST) begin
         cnt_q <= (!act_n_q) ? `SPVP_BIT_ONE : 5'h00;
      end else begin
         cnt_q <= cnt_q + `SPVP_BIT_ONE;
      end
      if (!act_n_q) begin
         sh_q <= {prog_serial_io_i, 14'h0000};
      end else begin
         sh_q <= {prog_serial_io_i, sh_q[14:1]};
      end
      bit3_q <= act_n_q && (cnt_q == `SPVP_BIT_CMD_LAST - `SPVP_BIT_ONE);
      last_q <= act_n_q && cnt_q == `SPVP_BIT_LAST;
   end

   // command decode at the fourth fall, frame hand-off at the twentieth
   always_ff @(negedge sclk) begin
      if (!act_n_q) begin
         cmd_q <= cmd_q;
         frame_q <= frame_q;
         rd_t_q <= rd_t_q;
         wr_t_q <= wr_t_q;
      end else if (cnt_q == `SPVP_BIT_CMD_LAST) begin
         cmd_q <= {prog_serial_io_i, sh_q[14:12]};
         if (cmd_is_read({prog_serial_io_i, sh_q[14:12]})) rd_t_q <= ~rd_t_q;
      end else if (cnt_q == `SPVP_BIT_LAST) begin
         frame_q <= {cmd_q, prog_serial_io_i, sh_q};
         if (!cmd_is_read(cmd_q)) wr_t_q <= ~wr_t_q;
      end
   end

   // read byte: launched on rising edges of the last eight operand bits
   always_ff @(posedge sclk) begin
      ack_s_q <= {ack_s_q[0], rd_ack_t_q};
      if (act_n_q && cnt_q == `SPVP_BIT_OUT_FIRST && cmd_is_read(cmd_q)) begin
         // byte only trusted once the ack toggle matches the request
         out_q <= (ack_s_q[1] == rd_t_q) ? table_latch_register_q : 8'h00;
         drive_q <= 1'b1;
      end else begin
         out_q <= {1'b0, out_q[7:1]};
         drive_q <= drive_q && act_n_q && cnt_q != 5'h00;
      end
   end

   // release right after the twentieth fall even if sclk then stops
   assign prog_serial_io_o = out_q[0];
   assign prog_serial_io_oe_n = ~(drive_q && !last_q);

endmodule : spvp_port

// [hdl/spvp_consts.svh]
// serial program/verify port: named offsets, codes, addresses and bit counts
// assumes it is included by bare name by the port module and the testbench
`ifndef SPVP_CONSTS_SVH
`define SPVP_CONSTS_SVH
// four-bit command codes, sent lsb first
`define SPVP_CMD_CORE 4'h0
`define SPVP_CMD_SHIFT_LATCH 4'h2
`define SPVP_CMD_RD 4'h8
`define SPVP_CMD_RD_POSTINC 4'h9
`define SPVP_CMD_RD_POSTDEC 4'ha
`define SPVP_CMD_RD_PREINC 4'hb
`define SPVP_CMD_WR 4'hc
`define SPVP_CMD_WR_POSTINC 4'hd
`define SPVP_CMD_WR_POSTDEC 4'he
`define SPVP_CMD_WR_PROG 4'hf
// bit positions inside one 20-bit instruction
`define SPVP_BIT_ONE 5'h01
`define SPVP_BIT_CMD_LAST 5'h03
`define SPVP_BIT_OUT_FIRST 5'h0c
`define SPVP_BIT_LAST 5'h13
// pointer register addresses in the core data space
`define SPVP_SFR_PTR_LOW 12'hff6
`define SPVP_SFR_PTR_HIGH 12'hff7
`define SPVP_SFR_PTR_UPPER 12'hff8
`define SPVP_UPPER_MASK 8'h3f
// memory map
`define SPVP_CODE_LAST 22'h01ffff
`define SPVP_BOOT_LAST 22'h0001ff
`define SPVP_ID_FIRST 22'h200000
`define SPVP_ID_LAST 22'h200007
`define SPVP_CFG_FIRST 22'h300000
`define SPVP_CFG_LAST 22'h30000d
`define SPVP_DEVID_FIRST 22'h3ffffe
`define SPVP_DEVID_LAST 22'h3fffff
`define SPVP_BLOCK_MSB 16
`define SPVP_BLOCK_LSB 14
`define SPVP_PANEL_MSB 16
`define SPVP_PANEL_LSB 13
`define SPVP_PROT_BOOT 8
// pointer steps
`define SPVP_RD_STEP 22'h000001
`define SPVP_WR_STEP 22'h000002
`endif

// [hdl/spvp_pkg.sv]
// serial program/verify port: shared types
// assumes spvp_consts.svh holds the numeric constants
package spvp_pkg;
   // program/verify entry mode
   typedef enum logic [1:0] {SPVP_MODE_OFF, SPVP_MODE_HV, SPVP_MODE_LV} spvp_mode_type;
   // system-side executor
   typedef enum logic [1:0] {SPVP_EX_IDLE, SPVP_EX_READ, SPVP_EX_WAIT} spvp_exec_type;
   // memory map region of a table address
   typedef enum logic [2:0] {SPVP_RG_CODE, SPVP_RG_ID, SPVP_RG_CFG, SPVP_RG_DEVID, SPVP_RG_NONE} spvp_region_type;
   // one shifted instruction
   typedef struct packed {
      logic [3:0] cmd;
      logic [15:0] operand;
   } spvp_frame_type;
endpackage : spvp_pkg

// [sim/spvp_port_checker.sv]
// checker: pin-level timing relations of the program/verify port
// assumes it is bound onto spvp_port and sees only its ports
`timescale 1ns/100ps
module spvp_port_checker (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic prog_serial_io_i,
   input wire logic prog_serial_io_oe_n,
   input wire logic high_programming_voltage,
   input wire logic low_volt_enable_bit,
   input wire logic prog_active,
   input wire logic hv_mode,
   input wire logic gpio_hiz,
   input wire logic low_volt_pin_dedicated,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [21:0] mem_addr,
   input wire logic [3:0] mem_panel,
   input wire logic mem_busy,
   input wire logic prog_start,
   input wire logic prog_hold
);
   // mode entry and exit; a window covers the two synchroniser flops
   chk_hv_entry_time: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(high_programming_voltage) && !sclk && !prog_serial_io_i && !prog_active |-> ##[2:5] prog_active && hv_mode)
      else $error("no entry");
   chk_entry_refused: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(high_programming_voltage) && prog_serial_io_i && !prog_active |-> !prog_active [*6])
      else $error("entry with data high");
   chk_hv_exit_time: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(high_programming_voltage) && hv_mode |-> ##[1:5] !prog_active)
      else $error("mode kept");
   chk_hiz_with_mode: assert property (@(posedge mclk) disable iff (sys_rst) gpio_hiz == prog_active)
      else $error("pins not released");
   chk_lv_pin_taken: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(low_volt_enable_bit) |-> ##[0:3] low_volt_pin_dedicated)
      else $error("entry pin not dedicated");
   // table access strobes
   chk_start_with_wr: assert property (@(posedge mclk) disable iff (sys_rst) prog_start |-> mem_wr)
      else $error("start without write");
   chk_panel_of_addr: assert property (@(posedge mclk) disable iff (sys_rst)
      mem_wr |-> mem_panel == mem_addr[16:13])
      else $error("panel mismatch");
   chk_busy_stalls: assert property (@(posedge mclk) disable iff (sys_rst)
      $past(mem_busy) && mem_busy |-> !mem_wr && !mem_rd)
      else $error("request during busy");
   chk_hold_needs_clk: assert property (@(posedge mclk) disable iff (sys_rst) prog_hold |-> $past(sclk, 2))
      else $error("hold with clock low");
   chk_drive_in_mode: assert property (@(posedge mclk) disable iff (sys_rst)
      !prog_serial_io_oe_n |-> prog_active)
      else $error("pin driven outside mode");
   // output half stays enabled for exactly seven sampled serial rises, then releases
   chk_out_half_len: assert property (@(posedge sclk) disable iff (sys_rst)
      $fell(prog_serial_io_oe_n) |-> !prog_serial_io_oe_n [*7] ##1 prog_serial_io_oe_n)
      else $error("output half length");
endmodule : spvp_port_checker

bind spvp_port spvp_port_checker chk (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
   .prog_serial_io_i(prog_serial_io_i), .prog_serial_io_oe_n(prog_serial_io_oe_n),
   .high_programming_voltage(high_programming_voltage), .low_volt_enable_bit(low_volt_enable_bit),
   .prog_active(prog_active), .hv_mode(hv_mode), .gpio_hiz(gpio_hiz),
   .low_volt_pin_dedicated(low_volt_pin_dedicated), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
   .mem_panel(mem_panel), .mem_busy(mem_busy), .prog_start(prog_start), .prog_hold(prog_hold));

// [sim/spvp_programmer.sv]
// programmer model: makes the serial clock and drives or releases the data pin
// assumes the bench resolves the pin from the device enable alone
`timescale 1ns/100ps
module spvp_programmer (
   output logic sclk,
   output logic data_o,
   output logic data_oe,
   input wire logic data_i
);
   // idle: clock stands still low, data held low
   initial begin
      sclk = 1'b0;
      data_o = 1'b0;
      data_oe = 1'b1;
   end
   task automatic set_data(input logic v);
      data_o <= v;
   endtask : set_data
   // one instruction, lsb first, launched on rise; hold stretches the 4th clock high and low
   task automatic shift(input logic [3:0] cmd, input logic [15:0] opd, input bit rd, input int hold,
      output logic [7:0] rb);
      logic [19:0] bits;
      bits = {opd, cmd};
      for (int i = 0; i < 20; i++) begin
         sclk = 1'b1;
         if (rd && i > 11) begin
            data_oe = 1'b0;
            data_o = ~data_o; // released line shows no stale level
         end else begin
            data_o = bits[i];
         end
         #15;
         if (i == 3) #(hold);
         if (i > 11) rb[i - 12] = data_i;
         sclk = 1'b0;
         #15;
         if (i == 3) #(hold);
      end
      data_oe = 1'b1;
      data_o = 1'b0;
   endtask : shift
endmodule : spvp_programmer

// [sim/testbench.sv]
// testbench: acts as core, memory and programmer around the port
// assumes the checker is bound and the model compiled before
`timescale 1ns/100ps
`include "spvp_consts.svh"
module testbench;
   logic mclk, sys_rst, hpv, mclr, lv_pin, lv_en, sfr_we, mem_busy, sclk, pdat, poe, pin, dev_o, dev_oe_n;
   logic act, hv, hiz, lv_ded, core_v, mem_rd, mem_wr, pstart, phold;
   logic [8:0] prot;
   logic [11:0] sfr_addr;
   logic [7:0] sfr_wdata, sfr_rdata, mem_rdata, rb;
   logic [15:0] core_instr, mem_wdata, core_seen, wr_data;
   logic [21:0] mem_addr, wr_addr;
   logic [3:0] panel, wr_panel;
   int num_errors = 0, samples_checked = 0, wr_cnt = 0, st_cnt = 0, hold_cnt = 0, core_cnt = 0, cyc = 0;
   localparam int limit = 20000;
   // shared data pin: device wins only while it enables
   assign pin = dev_oe_n ? pdat : dev_o;
   spvp_port uut (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .prog_serial_io_i(pin), .prog_serial_io_o(dev_o),
      .prog_serial_io_oe_n(dev_oe_n), .master_clear_vpp_pin(mclr), .high_programming_voltage(hpv),
      .low_volt_entry_pin(lv_pin), .low_volt_enable_bit(lv_en), .code_protect(prot), .prog_active(act),
      .hv_mode(hv), .gpio_hiz(hiz), .low_volt_pin_dedicated(lv_ded), .core_instr_valid(core_v),
      .core_instr(core_instr), .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_panel(panel),
      .mem_rdata(mem_rdata), .mem_busy(mem_busy), .prog_start(pstart), .prog_hold(phold));
   spvp_programmer prog (.sclk(sclk), .data_o(pdat), .data_oe(poe), .data_i(pin));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // memory answers straight from the registered address; events are tallied for the scenarios
   assign mem_rdata = mb(mem_addr);
   always @(posedge mclk) begin
      cyc++;
      if (mem_wr) begin
         wr_cnt++;
         wr_addr = mem_addr;
         wr_data = mem_wdata;
         wr_panel = panel;
      end
      if (pstart) st_cnt++;
      if (phold) hold_cnt++;
      if (core_v) begin
         core_cnt++;
         core_seen = core_instr;
      end
      if (cyc == limit) begin
         num_errors++;
         summarize();
      end
   end
   function automatic logic [7:0] mb(input logic [21:0] a);
      return a[7:0] ^ a[21:14];
   endfunction : mb
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // core-side register access; read data is registered one cycle behind the address
   task automatic sfr_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_we <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge mclk);
      sfr_we <= 1'b0;
   endtask : sfr_wr
   task automatic sfr_rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      repeat (2) @(posedge mclk);
      d = sfr_rdata;
   endtask : sfr_rd
   // stands in for the core instructions that load the pointer
   task automatic set_ptr(input logic [21:0] a);
      sfr_wr(`SPVP_SFR_PTR_UPPER, {2'h3, a[21:16]});
      sfr_wr(`SPVP_SFR_PTR_HIGH, a[15:8]);
      sfr_wr(`SPVP_SFR_PTR_LOW, a[7:0]);
   endtask : set_ptr
   task automatic check_ptr(input logic [21:0] a);
      logic [7:0] u, h, l;
      sfr_rd(`SPVP_SFR_PTR_UPPER, u);
      sfr_rd(`SPVP_SFR_PTR_HIGH, h);
      sfr_rd(`SPVP_SFR_PTR_LOW, l);
      check("pointer", {u, h, l}, {2'h0, a});
   endtask : check_ptr
   // off-phase start keeps serial edges away from system edges
   task automatic frame(input logic [3:0] c, input logic [15:0] o, input bit r, input int hold);
      #1.3;
      prog.shift(c, o, r, hold, rb);
      repeat (10) @(posedge mclk);
   endtask : frame
   task automatic t_entry();
      prog.set_data(1'b1);
      @(posedge mclk);
      hpv <= 1'b1;
      repeat (8) @(posedge mclk);
      check("refused", act, 1'b0);
      hpv <= 1'b0;
      prog.set_data(1'b0);
      repeat (8) @(posedge mclk);
      hpv <= 1'b1;
      repeat (12) @(posedge mclk);
      check("mode", {act, hv, hiz}, 3'h7);
   endtask : t_entry
   task automatic t_core();
      int c;
      c = core_cnt;
      frame(4'h1, 16'h1111, 0, 0);
      frame(`SPVP_CMD_CORE, 16'h6ef8, 0, 0);
      check("core", {24'(core_cnt - c), core_seen}, {8'h1, 16'h6ef8});
   endtask : t_core
   task automatic t_reads();
      logic [3:0] cmds [4] = '{`SPVP_CMD_RD, `SPVP_CMD_RD_POSTINC, `SPVP_CMD_RD_POSTDEC, `SPVP_CMD_RD_PREINC};
      int st [4] = '{0, 1, -1, 0};
      logic [21:0] a;
      for (int i = 0; i < 4; i++) begin
         a = 22'h001230 + 22'(i * 16);
         set_ptr(a);
         frame(cmds[i], 16'h00ff, 1, 0);
         if (i == 3) a = a + 22'h1;
         check("read", rb, mb(a));
         check_ptr(a + 22'(st[i]));
      end
      frame(`SPVP_CMD_SHIFT_LATCH, 16'h00ff, 1, 0);
      check("latch", rb, mb(a));
   endtask : t_reads
   task automatic t_writes();
      logic [3:0] cmds [4] = '{`SPVP_CMD_WR, `SPVP_CMD_WR_POSTINC, `SPVP_CMD_WR_POSTDEC, `SPVP_CMD_WR_PROG};
      int st [4] = '{0, 2, -2, 0};
      logic [21:0] a;
      int w, s;
      for (int i = 0; i < 4; i++) begin
         a = 22'h006002 + 22'(i * 8192);
         w = wr_cnt;
         s = st_cnt;
         set_ptr(a);
         frame(cmds[i], 16'hc35a + 16'(i), 0, 0);
         check("wr_addr", {2'(wr_cnt - w), wr_addr}, {2'h1, a});
         check("wr_data", {wr_panel, wr_data}, {a[16:13], 16'hc35a + 16'(i)});
         check("start", 24'(st_cnt - s), 24'(i == 3));
         check_ptr(a + 22'(st[i]));
      end
      check("no hold", 24'(hold_cnt), 24'h0);
      frame(`SPVP_CMD_CORE, 16'h0000, 0, 400);
      check("hold", 24'(hold_cnt > 75), 24'h1);
   endtask : t_writes
   task automatic t_regions();
      logic [8:0] pr [8] = '{9'h1ff, 9'h1ff, 9'h1ff, 9'h1ff, 9'h100, 9'h100, 9'h001, 9'h001};
      logic [21:0] ad [8] = '{22'h200007, 22'h30000d, 22'h3ffffe, 22'h004011, 22'h155, 22'h255, 22'h155, 22'h255};
      bit z [8] = '{0, 0, 0, 1, 1, 0, 0, 1};
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         prot <= pr[i];
         set_ptr(ad[i]);
         frame(`SPVP_CMD_RD, 16'h0000, 1, 0);
         check("region", rb, z[i] ? 8'h00 : mb(ad[i]));
      end
      prot <= 9'h000;
   endtask : t_regions
   task automatic t_busy();
      int w;
      w = wr_cnt;
      @(posedge mclk);
      mem_busy <= 1'b1;
      frame(`SPVP_CMD_WR, 16'h3c40, 0, 0);
      repeat (20) @(posedge mclk);
      check("stall", 24'(wr_cnt - w), 24'h0);
      mem_busy <= 1'b0;
      repeat (10) @(posedge mclk);
      check("resume", 24'(wr_cnt - w), 24'h1);
   endtask : t_busy
   task automatic t_lv();
      hpv <= 1'b0;
      lv_pin <= 1'b1;
      mclr <= 1'b1;
      repeat (8) @(posedge mclk);
      check("lv refused", {act, lv_ded}, 2'h0);
      mclr <= 1'b0;
      lv_en <= 1'b1;
      repeat (8) @(posedge mclk);
      mclr <= 1'b1;
      repeat (12) @(posedge mclk);
      check("lv mode", {act, hv, hiz, lv_ded}, 4'hb);
      frame(`SPVP_CMD_CORE, 16'h0e3c, 0, 0);
      check("lv core", core_seen, 16'h0e3c);
   endtask : t_lv
   initial begin
      sys_rst = 1'b1;
      {hpv, mclr, lv_pin, lv_en, sfr_we, mem_busy} = 6'h0;
      prot = 9'h000;
      sfr_addr = 12'h000;
      sfr_wdata = 8'h00;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge mclk);
      t_entry();
      t_core();
      t_reads();
      t_writes(); // write and verify before any configuration step
      t_regions();
      t_busy();
      t_lv();
      summarize();
   end
endmodule : testbench
